// ==== rtl/tws_pkg.sv ====
// Constants and types for the three-wire synchronous serial port
package tws_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [15:0] TWS_MODE_ADDR  = 16'hFFB0;
  localparam logic [15:0] TWS_DATA_ADDR  = 16'hFFB2;
  localparam int          TWS_EN_BIT     = 7;
  localparam int          TWS_MODE_BIT   = 2;
  localparam int          TWS_SEL_HI_BIT = 1;
  localparam int          TWS_SEL_LO_BIT = 0;
  localparam logic [7:0]  TWS_MODE_RESET = 8'h00;
  localparam logic [7:0]  TWS_DATA_RESET = 8'h00;
  localparam logic [1:0]  TWS_SEL_EXT    = 2'h0;

  // ****************************************************************
  // Counts
  // ****************************************************************
  localparam logic [3:0]  TWS_FRAME_BITS = 4'h8;
  localparam int          TWS_DIV_LOG2   = 6;   // Select 01 divides by 2**6

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic        wrEn;
    logic        rdEn;
    logic [7:0]  wrData;
    logic        bitWr;
    logic [2:0]  bitIdx;
    logic        bitVal;
  } tws_cpu_req_t;

  typedef struct packed {
    logic sckOut;
    logic sckOe;
    logic soOut;
    logic soOe;
    logic siUsed;
  } tws_pins_t;

  typedef struct packed {
    logic        enable;
    logic        rxOnly;
    logic [1:0]  clkSel;
    logic [7:0]  shift;
    logic [3:0]  bitCnt;
    logic        busy;
    logic [7:0]  divCnt;
    logic        sckLvl;
    logic        sckS1;
    logic        sckS2;
    logic        sckPrev;
    logic        siS1;
    logic        siS2;
    logic        soLatch;
    logic [7:0]  rdData;
    logic        donePulse;
    tws_pins_t   pins;
  } tws_state_t;

endpackage

// ==== rtl/tws_serial_port.sv ====
// Three-wire synchronous serial port with CPU register access
module tws_serial_port
  import tws_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire tws_cpu_req_t cpuReq,
  output tws_pins_t         pinsOut,
  output logic [7:0]        cpuRdData,
  output logic              transferDone,
  input  wire logic         sckIn,
  input  wire logic         siIn
);

  // ****************************************************************
  // State
  // ****************************************************************
  tws_state_t s;
  tws_state_t next_s;

  logic       extClk;
  logic [7:0] halfTerm;
  logic       divTick;
  logic       fallEdge;
  logic       riseEdge;
  logic       modeSel;
  logic       dataSel;
  logic [7:0] modeByte;

  // Register decode
  assign modeSel  = (cpuReq.addr == TWS_MODE_ADDR);
  assign dataSel  = (cpuReq.addr == TWS_DATA_ADDR);
  assign modeByte = {s.enable, 4'h0, s.rxOnly, s.clkSel};

  // Serial clock source and edges
  // Half period of select n is 2**(n+4) cycles, so a full period is 64/128/256
  assign extClk   = (s.clkSel == TWS_SEL_EXT);
  assign halfTerm = 8'((16'h0001 << (TWS_DIV_LOG2 - 1 + int'(s.clkSel) - 1)) - 16'h0001);
  assign divTick  = s.busy && !extClk && (s.divCnt == halfTerm);
  // External edges compare the second synchroniser stage with its previous value
  assign fallEdge = s.busy && (extClk ? (s.sckPrev && !s.sckS2)
                                      : (divTick && s.sckLvl));
  assign riseEdge = s.busy && (extClk ? (!s.sckPrev && s.sckS2)
                                      : (divTick && !s.sckLvl));

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_s           = s;
    next_s.donePulse = 1'b0;

    // Two flip-flops for the data input, three for the clock input
    next_s.sckS1   = sckIn;
    next_s.sckS2   = s.sckS1;
    next_s.sckPrev = s.sckS2;
    next_s.siS1    = siIn;
    next_s.siS2    = s.siS1;

    // Internal divider runs only inside a frame
    if (s.busy && !extClk) begin
      if (divTick) begin
        next_s.divCnt = 8'h00;
        next_s.sckLvl = !s.sckLvl;
      end else begin
        next_s.divCnt = s.divCnt + 8'h01;
      end
    end

    // Falling edge puts the current top bit on the output latch
    if (fallEdge) begin
      next_s.soLatch = s.shift[7];
    end

    // Rising edge samples input into the bottom, top bit leaves first
    if (riseEdge) begin
      next_s.shift  = {s.shift[6:0], s.siS2};
      next_s.bitCnt = s.bitCnt + 4'h1;
      if (s.bitCnt == TWS_FRAME_BITS - 4'h1) begin
        next_s.busy      = 1'b0;
        next_s.bitCnt    = 4'h0;
        next_s.divCnt    = 8'h00;
        next_s.sckLvl    = 1'b1;
        next_s.donePulse = 1'b1;
      end
    end

    // Mode register writes, whole byte or single bit
    if (cpuReq.wrEn && modeSel) begin
      next_s.enable = cpuReq.wrData[TWS_EN_BIT];
      next_s.rxOnly = cpuReq.wrData[TWS_MODE_BIT];
      next_s.clkSel = {cpuReq.wrData[TWS_SEL_HI_BIT], cpuReq.wrData[TWS_SEL_LO_BIT]};
    end else if (cpuReq.bitWr && modeSel) begin
      unique case (cpuReq.bitIdx)
        3'd7:    next_s.enable    = cpuReq.bitVal;
        3'd2:    next_s.rxOnly    = cpuReq.bitVal;
        3'd1:    next_s.clkSel[1] = cpuReq.bitVal;
        3'd0:    next_s.clkSel[0] = cpuReq.bitVal;
        default: next_s.enable    = s.enable;      // Fixed zero bits
      endcase
    end

    // Data writes: stored unless enabled in receive-only mode, start only when enabled in mode zero
    // Writes in receive-only mode while enabled are ignored to protect a running frame
    if (cpuReq.wrEn && dataSel && !(s.rxOnly && s.enable)) begin
      next_s.shift = cpuReq.wrData;
      if (s.enable && !s.busy) begin
        next_s.busy   = 1'b1;
        next_s.bitCnt = 4'h0;
        next_s.divCnt = 8'h00;
        next_s.sckLvl = 1'b1;
      end
    end

    // Reads answer one cycle later; a data-register read starts a receive-only frame
    next_s.rdData = 8'h00;
    if (cpuReq.rdEn) begin
      if (modeSel) begin
        next_s.rdData = modeByte;
      end else if (dataSel) begin
        next_s.rdData = s.shift;
        if (s.enable && s.rxOnly && !s.busy) begin
          next_s.busy   = 1'b1;
          next_s.bitCnt = 4'h0;
          next_s.divCnt = 8'h00;
          next_s.sckLvl = 1'b1;
        end
      end
    end

    // Disabled port: nothing runs and the counter stays clear
    // Uses the registered enable, so a write made while disabled never
    // leaves a pending start behind
    if (!s.enable) begin
      next_s.busy   = 1'b0;
      next_s.bitCnt = 4'h0;
      next_s.divCnt = 8'h00;
      next_s.sckLvl = 1'b1;
    end

    // Receive-only holds the output latch low
    if (next_s.rxOnly) begin
      next_s.soLatch = 1'b0;
    end

    // Pin ownership follows the next register values
    next_s.pins.sckOut = next_s.sckLvl;
    next_s.pins.sckOe  = next_s.enable && (next_s.clkSel != TWS_SEL_EXT);
    next_s.pins.soOut  = next_s.soLatch;
    next_s.pins.soOe   = next_s.enable && !next_s.rxOnly;
    next_s.pins.siUsed = next_s.enable;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Whole state resets; the shift value is cleared only for tidiness
  always_ff @(posedge clk) begin
    if (srst) begin
      s         <= '0;
      s.enable  <= TWS_MODE_RESET[TWS_EN_BIT];
      s.rxOnly  <= TWS_MODE_RESET[TWS_MODE_BIT];
      s.clkSel  <= TWS_MODE_RESET[1:0];
      s.shift   <= TWS_DATA_RESET;
      s.sckLvl  <= 1'b1;
      s.sckS1   <= 1'b1;
      s.sckS2   <= 1'b1;
      s.sckPrev <= 1'b1;
      s.pins    <= '{sckOut: 1'b1, sckOe: 1'b0, soOut: 1'b0, soOe: 1'b0, siUsed: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flip-flops
  assign pinsOut      = s.pins;
  assign cpuRdData    = s.rdData;
  assign transferDone = s.donePulse;

endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the serial port
module testbench;
  import tws_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk = 0;
  logic         srst = 1;
  logic         ld = 0;
  tws_cpu_req_t cpuReq = '0;
  tws_pins_t    pinsOut;
  logic [7:0]   cpuRdData;
  logic [7:0]   rx;
  logic [7:0]   tx = 8'h3C;
  logic         transferDone;
  logic         sck;
  logic         extSck = 1;
  logic         si;
  int           n_mismatch = 0;
  int           checks_done = 0;
  int           t;
  // Slave mode: clock pin is an input fed by the far side, idle high
  assign sck = pinsOut.sckOe ? pinsOut.sckOut : extSck;
  always #5 clk = ~clk;
  tws_serial_port dut (.clk(clk), .srst(srst), .cpuReq(cpuReq), .pinsOut(pinsOut),
    .cpuRdData(cpuRdData), .transferDone(transferDone), .sckIn(sck), .siIn(si));
  tws_peer peer (.sck(sck), .so(pinsOut.soOut), .tx(tx), .ld(ld), .si(si), .rx(rx));
  // **********
  // Tasks
  // **********
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 cpuReq.addr = a;
    cpuReq.wrData = d;
    cpuReq.wrEn = 1;
    @(posedge clk);
    #1 cpuReq.wrEn = 0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 cpuReq.addr = a;
    cpuReq.rdEn = 1;
    @(posedge clk);
    #1 cpuReq.rdEn = 0;
    chk(cpuRdData, exp);
  endtask
  // Bounded wait for the end of a frame
  task automatic frame(output int n);
    n = 0;
    while (transferDone !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // **********
  // Tests
  // **********
  initial begin
    repeat (4) @(posedge clk);
    #1 srst = 0;
    rd(TWS_MODE_ADDR, 8'h00);
    chk({pinsOut.sckOut, pinsOut.sckOe, pinsOut.soOe, pinsOut.siUsed}, 8'h08);
    wr(TWS_MODE_ADDR, 8'h7A);
    rd(TWS_MODE_ADDR, 8'h02);
    @(posedge clk);
    #1 cpuReq.bitWr = 1;
    cpuReq.bitVal = 1;
    @(posedge clk);
    #1 cpuReq.bitWr = 0;
    rd(TWS_MODE_ADDR, 8'h03);
    wr(16'hFFB4, 8'hFF);
    rd(16'hFFB4, 8'h00);
    wr(TWS_DATA_ADDR, 8'h55);
    wr(TWS_MODE_ADDR, 8'h81);
    frame(t);
    chk({7'h0, t < 3000}, 8'h00);
    // Each internal divider, timed and checked both ways
    for (int s = 1; s < 4; s++) begin
      wr(TWS_MODE_ADDR, 8'h80 | 8'(s));
      ld = ~ld;
      wr(TWS_DATA_ADDR, 8'hA5 ^ 8'(s));
      frame(t);
      t = t - (512 << (s - 1));
      chk({7'h0, t > -4 && t < 8}, 8'h01);
      chk(rx, 8'hA5 ^ 8'(s));
      chk({pinsOut.sckOut, pinsOut.sckOe, pinsOut.soOe, pinsOut.siUsed}, 8'h0F);
      rd(TWS_DATA_ADDR, tx);
    end
    // External clock: far side gives exactly eight slow pulses
    wr(TWS_MODE_ADDR, 8'h80);
    ld = ~ld;
    wr(TWS_DATA_ADDR, 8'h96);
    repeat (8) begin
      repeat (10) @(posedge clk);
      #1 extSck = 0;
      repeat (10) @(posedge clk);
      #1 extSck = 1;
    end
    frame(t);
    chk({7'h0, t < 8}, 8'h01);
    chk(rx, 8'h96);
    rd(TWS_DATA_ADDR, 8'h3C);
    wr(TWS_MODE_ADDR, 8'h85);
    tx = 8'hC3;
    ld = ~ld;
    rd(TWS_DATA_ADDR, 8'h3C);
    chk({pinsOut.soOe, pinsOut.siUsed}, 8'h01);
    frame(t);
    rd(TWS_DATA_ADDR, 8'hC3);
    repeat (100) @(posedge clk);
    wr(TWS_MODE_ADDR, 8'h05);
    frame(t);
    chk({7'h0, t < 3000}, 8'h00);
    wrap_up();
  end
  // Cut a hang short well past the expected run
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
endmodule

// ==== test/tws_monitor.sv ====
// Port-level assertions for the serial port
module tws_monitor
  import tws_pkg::*;
(
  input wire logic         clk,
  input wire logic         srst,
  input wire tws_cpu_req_t cpuReq,
  input wire tws_pins_t    pinsOut,
  input wire logic [7:0]   cpuRdData,
  input wire logic         transferDone,
  input wire logic         sckIn,
  input wire logic         siIn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // **********
  // Checks
  // **********
  done_pulse_a: assert property (transferDone |=> !transferDone)
    else $error("done pulse too long");
  done_enabled_a: assert property (transferDone |-> $past(pinsOut.siUsed))
    else $error("done while disabled");
  done_idle_a: assert property (transferDone |-> pinsOut.sckOut)
    else $error("clock not idle at done");
  pins_free_a: assert property (!pinsOut.siUsed |-> !pinsOut.sckOe && !pinsOut.soOe)
    else $error("pin held while disabled");
  rx_low_a: assert property ((pinsOut.siUsed && !pinsOut.soOe)[*2] |-> !pinsOut.soOut)
    else $error("output not low in receive mode");
  so_on_fall_a: assert property (pinsOut.soOe && $past(pinsOut.soOe) && pinsOut.sckOe
    && $changed(pinsOut.soOut) |-> !pinsOut.sckOut) else $error("output moved on high clock");
  sck_low_a: assert property ($fell(pinsOut.sckOut)
    |=> (!pinsOut.sckOut || !pinsOut.sckOe)[*8]) else $error("clock low half too short");
  mode_zero_a: assert property (cpuReq.rdEn && cpuReq.addr == TWS_MODE_ADDR
    |=> cpuRdData[6:3] == 4'h0) else $error("mode bits 6..3 not zero");
  read_idle_a: assert property (!cpuReq.rdEn |=> cpuRdData == 8'h00)
    else $error("read data not cleared");
endmodule

bind tws_serial_port tws_monitor mon (.clk(clk), .srst(srst), .cpuReq(cpuReq),
  .pinsOut(pinsOut), .cpuRdData(cpuRdData), .transferDone(transferDone),
  .sckIn(sckIn), .siIn(siIn));

// ==== test/tws_peer.sv ====
// Serial peripheral on the far side of the three wires
module tws_peer (
  input wire logic        sck,
  input wire logic        so,
  input wire logic [7:0]  tx,
  input wire logic        ld,
  output logic            si,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  // Load the byte to send on any toggle of ld
  always @(ld) sh = tx;
  // Shift out MSB first on falling clock, capture on rising
  always @(negedge sck) begin
    si = sh[7];
    sh = {sh[6:0], ~sh[7]}; // Fills with changing bits, not a stale level
  end
  always @(posedge sck) rx = {rx[6:0], so};
endmodule
